// >>> pmic_i2c_pkg.sv
/*
  Shared constants and types for the two-wire register slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pmic_i2c_pkg;

  // Own bus address; the value is arbitrary, the slave's SLAVE_ADDR parameter overrides it
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A;

  // Highest serial bit rate the master may use
  localparam int MAX_RATE_KBPS = 400;

  // Bit counter positions inside one nine-clock byte slot
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Direction bit value that asks for a read
  localparam logic RW_READ = 1'b1;

  // Register file size and reset content
  localparam int         IDX_W     = 6;
  localparam int         REG_DEPTH = 64;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_NONE   = 8'h00;

  // Where the link logic stands within a session
  typedef enum logic [2:0] {
    PH_ADDR   = 3'b000,
    PH_INDEX  = 3'b001,
    PH_DATA   = 3'b010,
    PH_RSTART = 3'b011,
    PH_READ   = 3'b100,
    PH_IGNORE = 3'b101
  } phase_e;

  // True when an address byte names this slave
  function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] a);
    addr_hit = (b[7:1] == a);
  endfunction

endpackage

`default_nettype wire

// >>> cond_if.sv
/*
  Carrier between the bus condition detector and the register slave core.
  Assumes both ends sit in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface cond_if;
  logic start_p;
  logic stop_p;
  logic busy_r;
  logic sess_clr_r;

  modport det  (output start_p, output stop_p, output busy_r, output sess_clr_r);
  modport core (input start_p, input stop_p, input busy_r, input sess_clr_r);
endinterface

`default_nettype wire

// >>> bus_cond_detect.sv
/*
  Start and stop condition detector, system clock side.
  Assumes scl and sda_in come straight from the pins, asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_cond_detect
  import pmic_i2c_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda_in,
  cond_if.det       cif
);

  logic scl_s1_r;
  logic scl_s2_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_s3_r;
  logic hold_r;

  // Two-stage synchronisers plus a third sda stage; the second stages and the third sda stage feed logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // Data edges while the clock line is high
  wire start_w = scl_s2_r && sda_s3_r && !sda_s2_r;
  wire stop_w  = scl_s2_r && !sda_s3_r && sda_s2_r;
  wire release_w = hold_r && !scl_s2_r;

  // Busy from start to stop; the link logic is held cleared while free
  // and across each start, and let go only once scl is low again, so the
  // release never lands near an scl edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cif.start_p    <= 1'b0;
      cif.stop_p     <= 1'b0;
      cif.busy_r     <= 1'b0;
      cif.sess_clr_r <= 1'b1;
      hold_r         <= 1'b0;
    end else begin
      cif.start_p <= start_w;
      cif.stop_p  <= stop_w;
      if (start_w) begin
        cif.busy_r     <= 1'b1;
        cif.sess_clr_r <= 1'b1;
        hold_r         <= 1'b1;
      end else if (stop_w) begin
        cif.busy_r     <= 1'b0;
        cif.sess_clr_r <= 1'b1;
        hold_r         <= 1'b0;
      end else if (release_w) begin
        cif.sess_clr_r <= 1'b0;
        hold_r         <= 1'b0;
      end
    end
  end

  start_busy_a: assert property (@(posedge clk) disable iff (rst)
    cif.start_p |-> cif.busy_r && cif.sess_clr_r)
    else $error("start did not mark the bus busy");

  busy_end_a: assert property (@(posedge clk) disable iff (rst)
    $fell(cif.busy_r) |-> cif.stop_p)
    else $error("bus went free without a stop");

  restart_release_a: assert property (@(posedge clk) disable iff (rst)
    $fell(cif.sess_clr_r) |-> cif.busy_r && !scl_s2_r)
    else $error("link released outside a session or with scl high");

endmodule

`default_nettype wire

// >>> pmic_i2c_register_slave.sv
/*
  Two-wire register slave: byte engine on the serial clock, register
  file and write strobes on the system clock.
  Assumes an external pull-up on sda and a master that drives scl.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Serial engine is clocked only by the master's scl.
// - Works at any bit rate up to 400 kbit/s.
// - Data line changes only while scl is low.
// - Data falling while scl high is a start.
// - Data rising while scl high is a stop; return to idle.
// - Bus busy from start until stop, free after.
// - Repeated start behaves as a first start, address again.
// - Bytes are eight bits, most significant bit first.
// - Transmitter releases data line; receiver pulls low on ninth pulse.
// - Once addressed, acknowledge every byte received.
// - First byte: seven-bit address plus direction, 0 write, 1 read.
// - Second write byte is the register index.
// - Third write byte is stored in the indexed register.
// - Own address is fixed per variant, not changeable at run time.
// - Acknowledge is driven by whichever party receives.

module pmic_i2c_register_slave
  import pmic_i2c_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  output var  logic       bus_busy,
  output var  logic       reg_wr_stb,
  output var  logic [7:0] reg_wr_idx,
  output var  logic [7:0] reg_wr_data
);

  // Bit position to send for a given count
  function automatic logic [2:0] tx_pos(input logic [3:0] c);
    tx_pos = 3'(LAST_BIT - c);
  endfunction

  cond_if cif ();

  bus_cond_detect u_cond (
    .clk    (clk),
    .rst    (rst),
    .scl    (scl),
    .sda_in (sda_in),
    .cif    (cif)
  );

  // Serial clock side state
  phase_e     phase_r;
  phase_e     phase_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic       ack_due_r;
  logic       sda_oe_n_r;
  logic       wr_tgl_r;
  logic       wr_kind_r;
  logic [7:0] wr_byte_r;

  // System clock side state
  logic       tgl_s1_r;
  logic       tgl_s2_r;
  logic       tgl_s3_r;
  logic [7:0] idx_r;
  logic [7:0] regs_r [REG_DEPTH];
  logic [7:0] rd_data_r;
  logic       sda_out_r;
  logic       reg_wr_stb_r;
  logic [7:0] reg_wr_idx_r;
  logic [7:0] reg_wr_data_r;

  // Serial engine is cleared by the condition detector, never by scl
  wire link_rst = cif.sess_clr_r;

  // Byte decode on the serial clock
  wire [7:0] byte_w    = {shift_r[6:0], sda_in};
  wire       byte_done = (bit_cnt_r == LAST_BIT);
  wire       ack_clk   = (bit_cnt_r == ACK_SLOT);
  wire       match_w   = addr_hit(byte_w, SLAVE_ADDR);
  wire       is_read   = (byte_w[0] == RW_READ);
  wire       wr_emit   = byte_done && (phase_r == PH_INDEX || phase_r == PH_DATA);

  // Acknowledge every received byte once addressed, none otherwise
  wire ack_nxt = (phase_r == PH_ADDR && match_w)
              || phase_r == PH_INDEX
              || phase_r == PH_DATA;

  // Read data comes from the register file and is refreshed per byte
  wire tx_load = ack_clk && (phase_r == PH_RSTART || (phase_r == PH_READ && !sda_in));

  // Pull low for our acknowledge, or for a zero data bit during a read
  wire drive_low = (ack_clk && ack_due_r)
                || (phase_r == PH_READ && !ack_clk && !tx_r[tx_pos(bit_cnt_r)]);

  assign bit_cnt_nxt = ack_clk ? 4'h0 : bit_cnt_r + 4'h1;

  // Session sequencing, decided at each byte or acknowledge boundary
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_ADDR: begin
        if (byte_done) begin
          if (!match_w) begin
            phase_nxt = PH_IGNORE;
          end else if (is_read) begin
            phase_nxt = PH_RSTART;
          end else begin
            phase_nxt = PH_INDEX;
          end
        end
      end
      PH_INDEX: begin
        if (byte_done) begin
          phase_nxt = PH_DATA;
        end
      end
      PH_DATA: begin
        phase_nxt = PH_DATA;
      end
      PH_RSTART: begin
        if (ack_clk) begin
          phase_nxt = PH_READ;
        end
      end
      PH_READ: begin
        if (ack_clk && sda_in) begin
          phase_nxt = PH_IGNORE;
        end
      end
      PH_IGNORE: begin
        phase_nxt = PH_IGNORE;
      end
      default: begin
        phase_nxt = PH_ADDR;
      end
    endcase
  end

  // Sampling on the rising serial clock edge; data is stable then
  always_ff @(posedge scl or posedge link_rst) begin
    if (link_rst) begin
      phase_r   <= PH_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ack_due_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      if (!ack_clk) begin
        shift_r <= byte_w;
      end
      if (byte_done) begin
        ack_due_r <= ack_nxt;
      end
    end
  end

  // Transmit byte; taken from a quasi-static word on the other clock
  always_ff @(posedge scl or posedge link_rst) begin
    if (link_rst) begin
      tx_r <= 8'hFF;
    end else if (tx_load) begin
      tx_r <= rd_data_r;
    end
  end

  // Drive only on the falling edge so sda never moves while scl is high
  always_ff @(negedge scl or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_n_r <= 1'b1;
    end else begin
      sda_oe_n_r <= !drive_low;
    end
  end

  // Write hand-off; kept out of the session clear so the toggle never
  // flips spuriously on a start
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      wr_tgl_r  <= 1'b0;
      wr_kind_r <= 1'b0;
      wr_byte_r <= 8'h00;
    end else if (wr_emit) begin
      wr_tgl_r  <= !wr_tgl_r;
      wr_kind_r <= (phase_r == PH_DATA);
      wr_byte_r <= byte_w;
    end
  end

  // Toggle synchroniser; the byte and kind are held for a whole byte
  // time after the toggle, far longer than the three-cycle latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= wr_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  wire             wr_new   = tgl_s2_r ^ tgl_s3_r;
  wire             idx_ok   = (idx_r[7:IDX_W] == '0);
  wire [IDX_W-1:0] idx_lo   = idx_r[IDX_W-1:0];
  wire             idx_wr   = wr_new && !wr_kind_r;
  wire             data_wr  = wr_new && wr_kind_r && idx_ok;

  // Register index latched from the second byte of a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 8'h00;
    end else if (idx_wr) begin
      idx_r <= wr_byte_r;
    end
  end

  // Register file; indices beyond it are dropped on write, read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (data_wr) begin
      regs_r[idx_lo] <= wr_byte_r;
    end
  end

  // Read word for the serial side. It only changes after an index or
  // data write, never while a read byte is being shifted out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= RD_NONE;
    end else begin
      rd_data_r <= idx_ok ? regs_r[idx_lo] : RD_NONE;
    end
  end

  // Write strobe toward the regulator control logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_stb_r  <= 1'b0;
      reg_wr_idx_r  <= 8'h00;
      reg_wr_data_r <= 8'h00;
    end else begin
      reg_wr_stb_r <= data_wr;
      if (data_wr) begin
        reg_wr_idx_r  <= idx_r;
        reg_wr_data_r <= wr_byte_r;
      end
    end
  end

  // Open-drain data: the driven level is always low
  // Kept in a register so this output, too, comes straight from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  // Outputs
  assign sda_out     = sda_out_r;
  assign sda_oe_n    = sda_oe_n_r;
  assign bus_busy    = cif.busy_r;
  assign reg_wr_stb  = reg_wr_stb_r;
  assign reg_wr_idx  = reg_wr_idx_r;
  assign reg_wr_data = reg_wr_data_r;

  ack_drive_a: assert property (@(posedge scl) disable iff (link_rst)
    (ack_clk && ack_due_r) |-> !sda_oe_n_r)
    else $error("received byte was not acknowledged");

  foreign_addr_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_ADDR && byte_done && !match_w)
      |=> (phase_r == PH_IGNORE && sda_oe_n_r))
    else $error("foreign address was acknowledged or not ignored");

  write_dir_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_ADDR && byte_done && match_w && !is_read)
      |=> phase_r == PH_INDEX ##8 phase_r == PH_INDEX)
    else $error("write direction did not lead to index byte");

  index_hand_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_INDEX && byte_done)
      |=> (wr_tgl_r != $past(wr_tgl_r)) && !wr_kind_r && phase_r == PH_DATA)
    else $error("index byte not handed over");

  msb_order_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_READ && !ack_clk) |-> sda_oe_n_r == tx_r[tx_pos(bit_cnt_r)])
    else $error("read bit out of order");

  read_nack_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_READ && ack_clk && sda_in)
      |=> (phase_r == PH_IGNORE && sda_oe_n_r))
    else $error("still driving after master nack");

  data_store_a: assert property (@(posedge clk) disable iff (rst)
    data_wr |=> reg_wr_stb_r && regs_r[$past(idx_lo)] == reg_wr_data_r)
    else $error("data byte not stored in indexed register");

  // Own read bytes leave the line free for the master's answer
  read_release_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_READ && ack_clk) |-> sda_oe_n_r)
    else $error("read byte did not release the line for the master answer");

  ignore_quiet_a: assert property (@(posedge scl) disable iff (link_rst)
    (phase_r == PH_IGNORE) |-> sda_oe_n_r)
    else $error("line driven while the session is ignored");

  data_ack_a: assert property (@(posedge scl) disable iff (link_rst)
    ((phase_r == PH_INDEX || phase_r == PH_DATA) && byte_done)
      |=> (ack_clk && !sda_oe_n_r))
    else $error("index or data byte not acknowledged");

  stb_single_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr_stb_r |=> !reg_wr_stb_r)
    else $error("write strobe longer than one cycle");

endmodule

`default_nettype wire

// >>> i2c_master_model.sv
/*
  Bus master model that drives scl and its share of sda.
  Assumes a link clock of 80 ns and a pull-up on the resolved sda.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  input  wire logic lclk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_m
);
  // Idle bus: both lines released high, scl stands still
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // One quarter bit of 8 link clocks keeps scl low above 1 us
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_m = d;
    repeat (8) @(posedge lclk);
  endtask

  // Start or restart: sda falls while scl high
  task automatic start();
    step(1'b0, sda_m);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  // Stop: sda rises while scl high
  task automatic stop();
    step(1'b0, sda_m);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // scl falls first so data never moves while scl is high
  task automatic bit1(input logic b, output logic r);
    step(1'b0, sda_m);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_in;
    step(1'b1, b);
  endtask

  // Eight bits MSB first, then the master-clocked ack slot
  task automatic xfer(input logic [7:0] d, input logic am,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r[i]);
    end
    bit1(am, a);
  endtask
endmodule

`default_nettype wire

// >>> pmic_i2c_register_slave_bench.sv
/*
  Self-checking bench for the two-wire register slave.
  Assumes the master model file is compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none

module pmic_i2c_register_slave_bench;
  import pmic_i2c_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary own address
  logic       clk;
  logic       rst;
  logic       lclk;
  logic       scl;
  logic       sda_m;
  logic       sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic       bus_busy;
  logic       reg_wr_stb;
  logic [7:0] reg_wr_idx;
  logic [7:0] reg_wr_data;
  int         miscompares = 0;
  int         total_checks = 0;
  int         stb_n = 0;
  int         cyc = 0;

  // Open drain with pull-up: either party can only pull low
  assign sda = sda_m & (sda_oe_n | sda_out);

  pmic_i2c_register_slave #(.SLAVE_ADDR(ADDR)) uut (
    .clk        (clk),
    .rst        (rst),
    .scl        (scl),
    .sda_in     (sda),
    .sda_out    (sda_out),
    .sda_oe_n   (sda_oe_n),
    .bus_busy   (bus_busy),
    .reg_wr_stb (reg_wr_stb),
    .reg_wr_idx (reg_wr_idx),
    .reg_wr_data(reg_wr_data)
  );

  i2c_master_model m (
    .lclk  (lclk),
    .sda_in(sda),
    .scl   (scl),
    .sda_m (sda_m)
  );

  // Two unrelated clocks; the link one only paces the model
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end

  // Strobe counter and hang guard; a full run needs about 27000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reg_wr_stb === 1'b1) begin
      stb_n <= stb_n + 1;
    end
    if (cyc == 80000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Master writes a byte; the expected ack level is compared
  task automatic wb(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic       a;
    m.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, ea});
  endtask

  // Master releases sda for eight bits and answers with am
  task automatic rb(input logic am, input logic [7:0] e);
    logic [7:0] r;
    logic       a;
    m.xfer(8'hFF, am, r, a);
    chk(r, e);
  endtask

  task automatic adr(input logic [6:0] a, input logic rw, input logic ea);
    m.start();
    wb({a, rw}, ea);
  endtask

  task automatic t_reset();
    chk({4'h0, sda_out, sda_oe_n, bus_busy, reg_wr_stb}, 8'h04);
    chk(reg_wr_idx, 8'h00);
    chk(reg_wr_data, 8'h00);
  endtask

  // Index then two data bytes back to back to one register
  task automatic t_write();
    int n0;
    n0 = stb_n;
    adr(ADDR, 1'b0, 1'b0);
    chk({7'h00, bus_busy}, 8'h01);
    wb(8'h05, 1'b0);
    wb(8'hA5, 1'b0);
    chk(reg_wr_idx, 8'h05);
    chk(reg_wr_data, 8'hA5);
    wb(8'h3C, 1'b0);
    chk(reg_wr_data, 8'h3C);
    chk(8'(stb_n - n0), 8'h02);
    m.stop();
    chk({7'h00, bus_busy}, 8'h00);
  endtask

  // Index write, restart with read, master ack then nack
  task automatic t_read();
    adr(ADDR, 1'b0, 1'b0);
    wb(8'h05, 1'b0);
    adr(ADDR, 1'b1, 1'b0);
    rb(1'b0, 8'h3C);
    rb(1'b1, 8'h3C);
    m.stop();
    chk({7'h00, sda_oe_n}, 8'h01);
  endtask

  // A restart in mid-write begins a fresh address phase
  task automatic t_restart();
    adr(ADDR, 1'b0, 1'b0);
    wb(8'h07, 1'b0);
    adr(ADDR, 1'b0, 1'b0);
    wb(8'h09, 1'b0);
    wb(8'h11, 1'b0);
    m.stop();
    chk(reg_wr_idx, 8'h09);
    chk(reg_wr_data, 8'h11);
  endtask

  // Foreign address is never acked; out-of-range index stores nothing
  task automatic t_refuse();
    int n0;
    n0 = stb_n;
    adr(7'h15, 1'b0, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h99, 1'b1);
    m.stop();
    adr(ADDR, 1'b0, 1'b0);
    wb(8'h40, 1'b0);
    wb(8'h77, 1'b0);
    adr(ADDR, 1'b1, 1'b0);
    rb(1'b1, RD_NONE);
    m.stop();
    chk(8'(stb_n - n0), 8'h00);
  endtask

  // Reset for three cycles with the bus idle, then the scenarios
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_write();
    t_read();
    t_restart();
    t_refuse();
    close_out();
  end
endmodule

`default_nettype wire
